/* File: slsr_strap_latch.sv */
// reset sequencer, strap latch and low-power control of a 10/100 physical layer
// assumes the management logic and status sources share clk_in; pins are async
//
// Behaviour
// - On power-on or reset the five address straps are sampled and become the 5-bit address.
// - A management write of the control register upper byte with reset set starts a reset.
// - The internal soft reset stays asserted for 500 ns, then drops on the clock.
// - When the soft reset drops, all mode and address strap levels are captured.
// - Address pin drivers are off from reset start until 1700 ns after its assertion.
// - Only management frames naming the latched address are accepted.
// - Low-power input at 100 Mb/s powers down the 10 Mb/s and auto-negotiation sections.
`timescale 1ns/1ps
module slsr_strap_latch
  import slsr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] address_strap_pins_in,
  output logic [ADDR_W-1:0] address_strap_pins_out,
  output logic [ADDR_W-1:0] address_strap_pins_oe_out,
  input wire logic [ADDR_W-1:0] status_drive_in,
  input wire logic [MODE_W-1:0] mode_strap_in,
  input wire logic ctrl_hi_wr_in,
  input wire logic ctrl_reset_bit_in,
  input wire logic [ADDR_W-1:0] mgmt_addr_in,
  input wire logic mgmt_addr_valid_in,
  output logic mgmt_sel_out,
  input wire logic low_power_in,
  input wire logic speed_100_in,
  output logic pwrdn_10_out,
  output logic pwrdn_an_out,
  output logic soft_reset_out,
  output logic [ADDR_W-1:0] phy_addr_out,
  output logic [MODE_W-1:0] mode_cfg_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    slsr_state_t st;
    logic [CNT_W-1:0] cnt;
    logic soft_rst;
    logic [ADDR_W-1:0] pin_oe;
    logic [ADDR_W-1:0] pin_do;
    logic [ADDR_W-1:0] phy_addr;
    logic [MODE_W-1:0] mode_cfg;
    logic mgmt_sel;
    logic pwrdn_10;
    logic pwrdn_an;
  } slsr_regs_t;

  localparam slsr_regs_t REGS_RST = '{
    st: ST_RESET,
    cnt: CNT_RST,
    soft_rst: 1'b1,
    pin_oe: '0,
    pin_do: '0,
    phy_addr: ADDR_RST,
    mode_cfg: MODE_RST,
    mgmt_sel: 1'b0,
    pwrdn_10: 1'b0,
    pwrdn_an: 1'b0
  };

  slsr_regs_t q;
  slsr_regs_t d;

  logic [ADDR_W-1:0] addr_sync;
  logic [MODE_W-1:0] mode_sync;
  logic low_power_sync;
  logic sw_req;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  slsr_sync #(.W(ADDR_W)) u_addr_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .async_in(address_strap_pins_in),
    .sync_out(addr_sync)
  );

  slsr_sync #(.W(MODE_W)) u_mode_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .async_in(mode_strap_in),
    .sync_out(mode_sync)
  );

  slsr_sync #(.W(1)) u_lp_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .async_in(low_power_in),
    .sync_out(low_power_sync)
  );

  // upper-byte write with the reset bit set
  assign sw_req = ctrl_hi_wr_in && ctrl_reset_bit_in;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.pin_do = status_drive_in;
    d.mgmt_sel = mgmt_addr_valid_in && !q.soft_rst && (mgmt_addr_in == q.phy_addr);
    d.pwrdn_10 = low_power_sync && speed_100_in;
    d.pwrdn_an = low_power_sync && speed_100_in;
    if (sw_req) begin
      // restart from any state, drivers off at once
      d.st = ST_RESET;
      d.cnt = CNT_RST;
      d.soft_rst = 1'b1;
      d.pin_oe = '0;
    end else begin
      case (q.st)
        ST_RESET: begin
          d.cnt = q.cnt + 1'b1;
          if (q.cnt == SW_RST_LAST) begin
            d.st = ST_HOLD;
            d.soft_rst = 1'b0;
            d.phy_addr = addr_sync;
            d.mode_cfg = mode_sync;
          end
        end
        ST_HOLD: begin
          d.cnt = q.cnt + 1'b1;
          if (q.cnt == OE_DIS_LAST) begin
            d.st = ST_RUN;
            d.pin_oe = '1;
          end
        end
        ST_RUN: begin
          d.cnt = CNT_RST;
        end
        default: begin
          d = REGS_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign address_strap_pins_out = q.pin_do;
  assign address_strap_pins_oe_out = q.pin_oe;
  assign mgmt_sel_out = q.mgmt_sel;
  assign pwrdn_10_out = q.pwrdn_10;
  assign pwrdn_an_out = q.pwrdn_an;
  assign soft_reset_out = q.soft_rst;
  assign phy_addr_out = q.phy_addr;
  assign mode_cfg_out = q.mode_cfg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  AST_ADDR_LATCH: assert property (
    $fell(soft_reset_out) |-> phy_addr_out == $past(addr_sync))
    else $error("address not taken from straps at reset release");

  AST_SW_START: assert property (
    (ctrl_hi_wr_in && ctrl_reset_bit_in) |=> soft_reset_out && q.cnt == CNT_RST
      && address_strap_pins_oe_out == '0)
    else $error("upper byte reset write did not start a reset");

  AST_RST_WIDTH: assert property (
    $fell(soft_reset_out) |-> $past(q.cnt) == SW_RST_LAST && $past(soft_reset_out))
    else $error("soft reset width wrong");

  AST_RST_HOLD: assert property (
    (soft_reset_out && q.cnt < SW_RST_LAST && !sw_req) |=> soft_reset_out)
    else $error("soft reset dropped early");

  AST_MODE_LATCH: assert property (
    $fell(soft_reset_out) |-> mode_cfg_out == $past(mode_sync) ##1 $stable(mode_cfg_out))
    else $error("mode straps not captured at reset release");

  AST_OE_OFF: assert property (
    (q.st != ST_RUN) |-> address_strap_pins_oe_out == '0)
    else $error("address pins driven during latch window");

  AST_OE_ON: assert property (
    $rose(address_strap_pins_oe_out[0]) |-> $past(q.cnt) == OE_DIS_LAST && !soft_reset_out)
    else $error("address pin drivers enabled at wrong time");

  AST_MGMT_SEL: assert property (
    (mgmt_addr_valid_in && mgmt_addr_in != phy_addr_out) |=> !mgmt_sel_out)
    else $error("management frame accepted at wrong address");

  AST_MGMT_HIT: assert property (
    (mgmt_addr_valid_in && mgmt_addr_in == phy_addr_out && !soft_reset_out) |=> mgmt_sel_out)
    else $error("management frame at own address not accepted");

  AST_MGMT_BUSY: assert property (
    (mgmt_addr_valid_in && soft_reset_out) |=> !mgmt_sel_out)
    else $error("management frame accepted during soft reset");

  AST_LOW_POWER: assert property (
    (low_power_sync && speed_100_in) |=> pwrdn_10_out && pwrdn_an_out)
    else $error("low power did not power down 10M and autoneg");

  AST_LOW_POWER_OFF: assert property (
    !(low_power_sync && speed_100_in) |=> !pwrdn_10_out && !pwrdn_an_out)
    else $error("sections powered down without low power at 100M");

  COV_SW_RESET_DONE: cover property (
    (ctrl_hi_wr_in && ctrl_reset_bit_in) ##1 soft_reset_out ##[1:60] !soft_reset_out);

  COV_OE_BACK: cover property ($rose(address_strap_pins_oe_out[0]));

  COV_MGMT_HIT: cover property (mgmt_sel_out);

  COV_LOW_POWER: cover property ($rose(pwrdn_10_out));

endmodule // slsr_strap_latch

/* File: slsr_pkg.sv */
// constants, types and timing helpers for the strap latch and soft reset block
// assumes a single 100 MHz clock domain
package slsr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int MODE_W = 8;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SW_RST_NS = 500;
  localparam int OE_DIS_NS = 1700;

  // least time, rounded up to whole cycles, never below one
  function automatic int slsr_ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SW_RST_CYC = slsr_ns_to_cyc(SW_RST_NS);
  localparam int OE_DIS_CYC = slsr_ns_to_cyc(OE_DIS_NS);
  localparam logic [CNT_W-1:0] SW_RST_LAST = CNT_W'(SW_RST_CYC - 1);
  localparam logic [CNT_W-1:0] OE_DIS_LAST = CNT_W'(OE_DIS_CYC - 1);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET,
    ST_HOLD,
    ST_RUN
  } slsr_state_t;

endpackage

/* File: slsr_sync.sv */
// two-flop synchroniser for pin inputs
// assumes the pins are asynchronous to clk_in
`timescale 1ns/1ps
module slsr_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } slsr_sync_regs_t;

  slsr_sync_regs_t q;
  slsr_sync_regs_t d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.meta = async_in;
    d.stab = q.meta;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stab;

endmodule // slsr_sync

/* File: slsr_mgmt_model.sv */
// management station model: control byte writes and addressed frames
// assumes its tasks are called from one process, clocked by clk_in
`timescale 1ns/1ps
module slsr_mgmt_model
  import slsr_pkg::*;
(
  input wire logic clk_in,
  output logic ctrl_hi_wr_out,
  output logic ctrl_reset_bit_out,
  output logic [ADDR_W-1:0] mgmt_addr_out,
  output logic mgmt_addr_valid_out
);
  initial begin
    ctrl_hi_wr_out = 1'b0;
    ctrl_reset_bit_out = 1'b0;
    mgmt_addr_out = 5'h00;
    mgmt_addr_valid_out = 1'b0;
  end
  // one-cycle upper byte write; released data shows its inverse
  task automatic wr_ctrl(input logic rst_bit);
    @(posedge clk_in);
    #1;
    ctrl_hi_wr_out = 1'b1;
    ctrl_reset_bit_out = rst_bit;
    @(posedge clk_in);
    #1;
    ctrl_hi_wr_out = 1'b0;
    ctrl_reset_bit_out = ~rst_bit;
  endtask
  task automatic frame(input logic [ADDR_W-1:0] addr);
    @(posedge clk_in);
    #1;
    mgmt_addr_valid_out = 1'b1;
    mgmt_addr_out = addr;
    @(posedge clk_in);
    #1;
    mgmt_addr_valid_out = 1'b0;
    mgmt_addr_out = ~addr;
  endtask
endmodule // slsr_mgmt_model

/* File: slsr_strap_latch_tb.sv */
// self-checking testbench for the strap latch and soft reset block
// assumes slsr_pkg, the design files and the management model compile first
`timescale 1ns/1ps
module slsr_strap_latch_tb import slsr_pkg::*;;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [ADDR_W-1:0] strap = 5'h00;
  logic [ADDR_W-1:0] stat = 5'h00;
  logic [MODE_W-1:0] mode = 8'h00;
  logic lp = 1'b0;
  logic spd = 1'b0;
  logic [ADDR_W-1:0] pins, oe, pin_lvl, maddr, paddr, a, taken_a;
  logic [MODE_W-1:0] mcfg;
  logic hi_wr, rst_bit, mvalid, sel, pd10, pdan, srst;
  int err_total = 0;
  int cmp_count = 0;
  logic [ADDR_W-1:0] exp_q[$];
  always #5 clk_in = ~clk_in;
  // pin level: design drive where enabled, strap resistor elsewhere
  assign pin_lvl = (oe & pins) | (~oe & strap);
  slsr_mgmt_model mgmt (.clk_in(clk_in), .ctrl_hi_wr_out(hi_wr), .ctrl_reset_bit_out(rst_bit),
    .mgmt_addr_out(maddr), .mgmt_addr_valid_out(mvalid));
  slsr_strap_latch dut (.clk_in(clk_in), .rstn_in(rstn_in), .address_strap_pins_in(pin_lvl),
    .address_strap_pins_out(pins), .address_strap_pins_oe_out(oe), .status_drive_in(stat),
    .mode_strap_in(mode), .ctrl_hi_wr_in(hi_wr), .ctrl_reset_bit_in(rst_bit),
    .mgmt_addr_in(maddr), .mgmt_addr_valid_in(mvalid), .mgmt_sel_out(sel),
    .low_power_in(lp), .speed_100_in(spd), .pwrdn_10_out(pd10), .pwrdn_an_out(pdan),
    .soft_reset_out(srst), .phy_addr_out(paddr), .mode_cfg_out(mcfg));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // waits out a reset sequence, counting reset and driver-off cycles
  task automatic seq(input bit cnt);
    int n;
    int ns;
    n = 0;
    ns = 0;
    while (oe !== 5'h1F && n < 400) begin
      if (srst === 1'b1) ns++;
      if (cnt) chk("oe_off", oe, 8'h00);
      cyc(1);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      test_done();
    end
    if (cnt) chk("srst_len", ns[7:0], 8'(SW_RST_CYC));
    if (cnt) chk("oe_len", n[7:0], 8'(OE_DIS_CYC));
    chk("addr", paddr, strap);
    chk("mode", mcfg, mode);
    cyc(2);
    chk("drive", pins, stat);
  endtask
  // address of the last frame taken
  always @(posedge clk_in) begin
    if (mvalid === 1'b1) taken_a <= maddr;
  end
  // selection pulses against the noted addresses, sampled mid-cycle
  always @(negedge clk_in) begin
    if (sel === 1'b1) begin
      if (exp_q.size() == 0) chk("sel_extra", 8'h01, 8'h00);
      else chk("sel_addr", taken_a, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    test_done();
  end
  initial begin
    void'($urandom(32'hC5488F5E));
    strap = $urandom;
    mode = $urandom;
    stat = $urandom;
    cyc(16);
    chk("rst_srst", srst, 8'h01);
    chk("rst_oe", oe, 8'h00);
    rstn_in = 1'b1;
    seq(1'b0);
    $display("test hw_reset done");
    mgmt.wr_ctrl(1'b1);
    mgmt.frame(paddr);
    strap = $urandom;
    mode = $urandom;
    cyc(15);
    mgmt.wr_ctrl(1'b1);
    seq(1'b1);
    $display("test soft_reset_restart done");
    mgmt.wr_ctrl(1'b0);
    cyc(3);
    chk("no_rst", srst, 8'h00);
    chk("no_oe_off", oe, 8'h1F);
    $display("test refused_write done");
    for (int i = 0; i < 12; i++) begin
      a = (i % 3 == 0) ? strap : 5'($urandom);
      if (a == strap) exp_q.push_back(a);
      mgmt.frame(a);
    end
    cyc(3);
    chk("sel_missing", 8'(exp_q.size()), 8'h00);
    $display("test mgmt_match done");
    rstn_in = 1'b0;
    strap = $urandom;
    mode = $urandom;
    cyc(3);
    chk("hw_srst", srst, 8'h01);
    chk("hw_oe", oe, 8'h00);
    chk("hw_addr", paddr, 8'(ADDR_RST));
    chk("hw_mode", mcfg, MODE_RST);
    rstn_in = 1'b1;
    seq(1'b1);
    $display("test hw_reset_mid done");
    for (int i = 0; i < 4; i++) begin
      lp = i[1];
      spd = i[0];
      cyc(5);
      chk("pd10", pd10, i[1] & i[0]);
      chk("pdan", pdan, i[1] & i[0]);
    end
    $display("test low_power done");
    test_done();
  end
endmodule // slsr_strap_latch_tb
